// File: hdl/serial_reg_slave.sv
`timescale 1ns/1ns
`default_nettype none
// pin front end of the two-wire register slave; pins sampled as synchronous inputs
module serial_reg_slave (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   // bus events
   output logic o_scl_rise,
   output logic o_scl_fall,
   output logic o_start,
   output logic o_stop
);
   logic scl_q, scl_d;
   logic sda_q, sda_d;

   // previous pin levels
   always_comb begin
      scl_d = i_scl;
      sda_d = i_sda;
   end

   // reset to the idle-high level so leaving reset shows no false edge
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end

   // events stay combinational so the engine acts in the cycle the pin moved
   assign o_scl_rise = i_scl & ~scl_q;
   assign o_scl_fall = ~i_scl & scl_q;
   assign o_start = i_scl & scl_q & sda_q & ~i_sda; // data falls, clock high
   assign o_stop = i_scl & scl_q & ~sda_q & i_sda; // data rises, clock high
endmodule // serial_reg_slave
`default_nettype wire

// File: hdl/video_ctrl_pkg.sv
package video_ctrl_pkg;

   // register sub-addresses on the serial bus
   localparam logic [7:0] SUBADDR_OUTPUT_FEATURE = 8'h02;
   localparam logic [7:0] SUBADDR_LUMA_SCALE = 8'h03;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h44; // arbitrary bus address

   // field positions in output_feature_control
   localparam int SYNC_ON_GREEN_BIT = 6;
   localparam int FIELD_POL_BIT = 5;
   localparam int TRAP_EN_BIT = 4;
   localparam int COLOR_BAR_BIT = 3;
   localparam int OVL_LEVEL_MSB = 2;
   localparam int OVL_LEVEL_LSB = 1;
   localparam int SAMPLING_BIT = 0;

   // values after reset, and the highest luma code before clamping
   localparam logic [7:0] OUTPUT_FEATURE_RESET = 8'h00;
   localparam logic [7:0] LUMA_SCALE_RESET = 8'h00;
   localparam logic [3:0] LUMA_CODE_MAX = 4'ha;

   // clocking of the filter chain
   localparam int PROC_CLOCK_MHZ = 27;

   // decoded control fields handed to the video path
   typedef struct packed {
      logic sync_on_green_insert;
      logic field_invert;
      logic trap_enable;
      logic color_bar;
      logic [1:0] overlay_level;
      logic sampling_411;
      logic [3:0] luma_code;
   } video_ctrl_t;

   // overlay / colour-bar gain in 1/4 steps: 00 -> 4/4 .. 11 -> 1/4
   function automatic logic [2:0] overlay_gain_quarters(input logic [1:0] code);
      overlay_gain_quarters = 3'h4 - {1'b0, code};
   endfunction

   // luma gain in 1/32 steps: code 0 -> 32/32, each step -1/32 up to code 10 (22/32), higher codes held there
   function automatic logic [5:0] luma_gain_32nds(input logic [3:0] code);
      logic [3:0] c;
      c = (code > LUMA_CODE_MAX) ? LUMA_CODE_MAX : code;
      luma_gain_32nds = 6'h20 - {2'b00, c};
   endfunction

endpackage

// File: hdl/video_encoder_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - With RGB output active, sync is added to green only when control bit 6 is set.
// - The field output is high in odd fields unless bit 5 inverts it.
// - The luma trap filter is used only when bit 4 is set.
// - Bit 3 replaces the picture by a luminance-ordered colour bar.
// - Bits 2:1 scale overlay and colour bar to 100, 75, 50 or 25 percent.
// - The four-bit luma code lowers picture luminance by 1/32 per step down to 68.75%.
// - Chroma passes a low-pass and interpolation chain specified at a 27 MHz clock.
module video_encoder_control_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // serial host pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe,
   // video status
   input wire logic i_rgb_mode,
   input wire logic i_odd_field,
   // decoded controls
   output video_ctrl_pkg::video_ctrl_t o_ctrl,
   output logic o_sync_on_green,
   output logic o_field_identity_output,
   output logic o_trap_enable,
   output logic o_color_bar_select,
   output logic [2:0] o_overlay_gain_quarters,
   output logic [5:0] o_luma_gain_32nds,
   output logic o_sampling_411,
   output logic o_chroma_lowpass_enable
);
   logic [7:0] output_feature_control_q, output_feature_control_d;
   logic [7:0] luminance_scale_control_q, luminance_scale_control_d;
   logic wr_valid;
   logic [7:0] wr_addr, wr_data;
   logic scl_rise, scl_fall, start_c, stop_c;

   // serial engine state; no read path, both registers are write-only
   typedef enum {ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_ACK, ST_SKIP} state_t;
   state_t state_q, state_d;
   state_t after_ack_q, after_ack_d;
   logic [7:0] shift_q, shift_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] addr_q, addr_d;
   logic ack_q, ack_d;
   logic wr_valid_q, wr_valid_d;
   logic [7:0] wr_data_q, wr_data_d;
   logic [7:0] wr_addr_q, wr_addr_d;

   // pin front end: sampled levels, clock edges, start and stop
   serial_reg_slave u_slave (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_scl_rise(scl_rise),
      .o_scl_fall(scl_fall),
      .o_start(start_c),
      .o_stop(stop_c)
   );

   // byte engine; the sub-address steps after each data byte so one burst
   // loads both registers
   always_comb begin
      state_d = state_q;
      after_ack_d = after_ack_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      ack_d = ack_q;
      wr_valid_d = 1'b0;
      wr_data_d = wr_data_q;
      wr_addr_d = wr_addr_q;
      if (start_c) begin
         state_d = ST_ADDR;
         cnt_d = 4'h0;
         ack_d = 1'b0;
      end else if (stop_c) begin
         state_d = ST_IDLE;
         ack_d = 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_SUB, ST_DATA: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], i_sda};
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == 4'h8) begin
                  cnt_d = 4'h0;
                  if (state_q == ST_ADDR) begin
                     // reads are not supported: no acknowledge, ignore rest
                     if (shift_q[7:1] == video_ctrl_pkg::DEV_ADDR_DEFAULT && !shift_q[0]) begin
                        ack_d = 1'b1;
                        after_ack_d = ST_SUB;
                        state_d = ST_ACK;
                     end else begin
                        state_d = ST_SKIP;
                     end
                  end else begin
                     ack_d = 1'b1;
                     after_ack_d = ST_DATA;
                     state_d = ST_ACK;
                     if (state_q == ST_SUB) begin
                        addr_d = shift_q;
                     end else begin
                        wr_valid_d = 1'b1;
                        wr_data_d = shift_q;
                        wr_addr_d = addr_q;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  ack_d = 1'b0;
                  state_d = after_ack_q;
               end
            end
            ST_IDLE, ST_SKIP: begin
            end
            default: state_d = ST_IDLE;
         endcase
      end
      // step the sub-address the cycle after a data byte is strobed
      if (wr_valid_q) begin
         addr_d = addr_q + 8'h01;
      end
   end

   // registers of the byte engine
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q <= ST_IDLE;
         after_ack_q <= ST_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         addr_q <= 8'h00;
         ack_q <= 1'b0;
         wr_valid_q <= 1'b0;
         wr_data_q <= 8'h00;
         wr_addr_q <= 8'h00;
      end else begin
         state_q <= state_d;
         after_ack_q <= after_ack_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         ack_q <= ack_d;
         wr_valid_q <= wr_valid_d;
         wr_data_q <= wr_data_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   // ack pulls the open-drain line low while enabled
   assign o_sda_oe = ack_q;
   assign wr_valid = wr_valid_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;

   // write decode; other sub-addresses belong to other blocks
   always_comb begin
      output_feature_control_d = output_feature_control_q;
      luminance_scale_control_d = luminance_scale_control_q;
      if (wr_valid && wr_addr == video_ctrl_pkg::SUBADDR_OUTPUT_FEATURE) begin
         output_feature_control_d = wr_data;
      end
      if (wr_valid && wr_addr == video_ctrl_pkg::SUBADDR_LUMA_SCALE) begin
         luminance_scale_control_d = wr_data;
      end
   end

   // control registers; they only move on a strobed write
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         output_feature_control_q <= video_ctrl_pkg::OUTPUT_FEATURE_RESET;
         luminance_scale_control_q <= video_ctrl_pkg::LUMA_SCALE_RESET;
      end else begin
         output_feature_control_q <= output_feature_control_d;
         luminance_scale_control_q <= luminance_scale_control_d;
      end
   end

   // field decode of the stored controls
   video_ctrl_pkg::video_ctrl_t ctrl_c;
   always_comb begin
      ctrl_c.sync_on_green_insert =
         output_feature_control_q[video_ctrl_pkg::SYNC_ON_GREEN_BIT];
      ctrl_c.field_invert = output_feature_control_q[video_ctrl_pkg::FIELD_POL_BIT];
      ctrl_c.trap_enable = output_feature_control_q[video_ctrl_pkg::TRAP_EN_BIT];
      ctrl_c.color_bar = output_feature_control_q[video_ctrl_pkg::COLOR_BAR_BIT];
      ctrl_c.overlay_level = output_feature_control_q[video_ctrl_pkg::OVL_LEVEL_MSB:
                                                      video_ctrl_pkg::OVL_LEVEL_LSB];
      ctrl_c.sampling_411 = output_feature_control_q[video_ctrl_pkg::SAMPLING_BIT];
      ctrl_c.luma_code = luminance_scale_control_q[3:0];
   end

   // registered data outputs to the video path
   video_ctrl_pkg::video_ctrl_t ctrl_q;
   logic sog_q, fid_q;
   logic [2:0] ovl_q;
   logic [5:0] luma_q;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_q <= '0;
         sog_q <= 1'b0;
         fid_q <= 1'b0;
         ovl_q <= 3'h4;
         luma_q <= 6'h20;
      end else begin
         ctrl_q <= ctrl_c;
         sog_q <= i_rgb_mode & ctrl_c.sync_on_green_insert;
         fid_q <= i_odd_field ^ ctrl_c.field_invert;
         ovl_q <= video_ctrl_pkg::overlay_gain_quarters(ctrl_c.overlay_level);
         luma_q <= video_ctrl_pkg::luma_gain_32nds(ctrl_c.luma_code);
      end
   end

   assign o_ctrl = ctrl_q;
   assign o_sync_on_green = sog_q;
   assign o_field_identity_output = fid_q;
   assign o_trap_enable = ctrl_q.trap_enable;
   assign o_color_bar_select = ctrl_q.color_bar;
   assign o_overlay_gain_quarters = ovl_q;
   assign o_luma_gain_32nds = luma_q;
   assign o_sampling_411 = ctrl_q.sampling_411;
   // chroma filter chain in path whenever out of reset; its response is a 27 MHz design point
   assign o_chroma_lowpass_enable = ~i_reset;
endmodule // video_encoder_control_regs
`default_nettype wire

// File: test/serial_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host on the two-wire bus; a released data line reads high via pull-up
module serial_host_model (
   // clock and resolved data line
   input wire logic i_clk,
   input wire logic i_sda,
   // host drive
   output logic o_scl,
   output logic o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // eight cycles a phase so the synchronous sampler sees every level
   task automatic hold(input logic c, input logic d);
      o_scl = c;
      o_sda = d;
      repeat (8) @(negedge i_clk);
   endtask
   // start, four bytes with ack slots, stop
   task automatic write(input logic [7:0] q [4], output int acks);
      acks = 0;
      hold(1'b1, 1'b1);
      hold(1'b1, 1'b0);
      foreach (q[k]) begin
         for (int i = 7; i >= 0; i--) begin
            hold(1'b0, q[k][i]);
            hold(1'b1, q[k][i]);
         end
         hold(1'b0, 1'b1);
         hold(1'b1, 1'b1);
         acks += int'(!i_sda);
      end
      hold(1'b0, 1'b0);
      hold(1'b1, 1'b0);
      hold(1'b1, 1'b1);
   endtask
endmodule // serial_host_model
`default_nettype wire

// File: test/vec_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// port-level watch on the control bank
module vec_ctrl_checker (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // bus and video inputs
   input wire logic i_scl,
   input wire logic i_rgb_mode,
   input wire logic i_odd_field,
   // decoded outputs
   input wire video_ctrl_pkg::video_ctrl_t o_ctrl,
   input wire logic o_sync_on_green,
   input wire logic o_field_identity_output,
   input wire logic o_trap_enable,
   input wire logic o_color_bar_select,
   input wire logic [2:0] o_overlay_gain_quarters,
   input wire logic [5:0] o_luma_gain_32nds,
   input wire logic o_sampling_411,
   input wire logic o_chroma_lowpass_enable
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // registers may only move while the host holds the bus clock low
   sequence scl_low;
      !i_scl;
   endsequence
   chk_sync_green: assert property (
      o_sync_on_green == ($past(i_rgb_mode) & o_ctrl.sync_on_green_insert))
      else $error("sync on green mismatch");
   chk_field_pol: assert property (
      !$past(i_reset) |-> o_field_identity_output == ($past(i_odd_field) ^ o_ctrl.field_invert))
      else $error("field output mismatch");
   chk_trap_bit: assert property (o_trap_enable == o_ctrl.trap_enable)
      else $error("trap enable mismatch");
   chk_bar_bit: assert property (o_color_bar_select == o_ctrl.color_bar)
      else $error("colour bar mismatch");
   chk_ovl_gain: assert property (
      o_overlay_gain_quarters == 3'h4 - {1'b0, o_ctrl.overlay_level})
      else $error("overlay gain mismatch");
   chk_luma_gain: assert property (
      o_luma_gain_32nds == 6'h20 - ((o_ctrl.luma_code > 4'ha) ? 6'h0a : {2'h0, o_ctrl.luma_code}))
      else $error("luma gain mismatch");
   chk_lpf_on: assert property ($past(!i_reset) |-> o_chroma_lowpass_enable)
      else $error("chroma lowpass off");
   chk_ratio_bit: assert property (o_sampling_411 == o_ctrl.sampling_411)
      else $error("sampling ratio mismatch");
   chk_ctrl_quiet: assert property (
      !$past(i_reset) && $changed(o_ctrl) |-> scl_low)
      else $error("control moved with bus clock high");
endmodule // vec_ctrl_checker
`default_nettype wire

// File: test/video_encoder_control_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module video_encoder_control_regs_tb;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic rgb = 1'b0;
   logic odd = 1'b0;
   logic scl, sda_h, sda_oe, sog, fid, trap, cbar, s411, chroma_lowpass;
   wire logic sda;
   logic [2:0] ovl;
   logic [5:0] luma;
   video_ctrl_pkg::video_ctrl_t ctrl;
   logic [31:0] lfsr = 32'h0001_10bb;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int r0, r1, acks;
   // pull-up line, low when either side pulls
   assign sda = sda_h & ~sda_oe;
   always #4 i_clk = ~i_clk;
   video_encoder_control_regs i_video_encoder_control_regs (.i_clk(i_clk), .i_reset(i_reset),
      .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe), .i_rgb_mode(rgb), .i_odd_field(odd),
      .o_ctrl(ctrl), .o_sync_on_green(sog), .o_field_identity_output(fid), .o_trap_enable(trap),
      .o_color_bar_select(cbar), .o_overlay_gain_quarters(ovl), .o_luma_gain_32nds(luma),
      .o_sampling_411(s411), .o_chroma_lowpass_enable(chroma_lowpass));
   serial_host_model i_serial_host_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // model comparison once outputs have settled
   task automatic compare();
      int lc;
      repeat (3) @(negedge i_clk);
      lc = (r1 % 16 > 10) ? 10 : r1 % 16;
      chk("ctrl", ctrl, 11'({r0[6:0], r1[3:0]}));
      chk("sync", sog, rgb & r0[6]);
      chk("field", fid, odd ^ r0[5]);
      chk("trap", trap, r0[4]);
      chk("bar", cbar, r0[3]);
      chk("ovl", ovl, 11'(4 - r0[2:1]));
      chk("luma", luma, 11'(32 - lc));
      chk("ratio", s411, r0[0]);
      chk("lpf", chroma_lowpass, 1'b1);
   endtask
   task automatic wr(input logic [7:0] dev, sub, d0, d1, input int exp_acks);
      i_serial_host_model.write('{dev, sub, d0, d1}, acks);
      chk("acks", 11'(acks), 11'(exp_acks));
      if (exp_acks == 4 && sub == 8'h02) r0 = d0;
      if (exp_acks == 4 && sub == 8'h02) r1 = d1;
      if (exp_acks == 4 && sub == 8'h03) r1 = d0;
      compare();
   endtask
   // hang guard
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      r0 = 0;
      r1 = 0;
      repeat (3) @(negedge i_clk);
      i_reset = 1'b0;
      compare();
      // every level code and luma code, random other bits
      for (int k = 0; k < 16; k++) begin
         lfsr = next_rand(lfsr);
         rgb = lfsr[0];
         odd = lfsr[1];
         wr(8'h88, 8'h02, {lfsr[15:11], k[1:0], lfsr[8]}, {lfsr[7:4], k[3:0]}, 4);
      end
      wr(8'h8a, 8'h02, 8'h00, 8'h00, 0);
      // own address with the read bit set is refused as well
      wr(8'h89, 8'h02, 8'h00, 8'h00, 0);
      wr(8'h88, 8'h05, 8'hff, 8'hff, 4);
      wr(8'h88, 8'h03, 8'h0c, 8'h00, 4);
      // reset in mid-run restores defaults
      i_reset = 1'b1;
      @(negedge i_clk);
      i_reset = 1'b0;
      r0 = 0;
      r1 = 0;
      compare();
      report_and_stop();
   end
endmodule // video_encoder_control_regs_tb
bind video_encoder_control_regs vec_ctrl_checker i_chk (
   .i_clk(i_clk),
   .i_reset(i_reset),
   .i_scl(i_scl),
   .i_rgb_mode(i_rgb_mode),
   .i_odd_field(i_odd_field),
   .o_ctrl(o_ctrl),
   .o_sync_on_green(o_sync_on_green),
   .o_field_identity_output(o_field_identity_output),
   .o_trap_enable(o_trap_enable),
   .o_color_bar_select(o_color_bar_select),
   .o_overlay_gain_quarters(o_overlay_gain_quarters),
   .o_luma_gain_32nds(o_luma_gain_32nds),
   .o_sampling_411(o_sampling_411),
   .o_chroma_lowpass_enable(o_chroma_lowpass_enable)
);
`default_nettype wire
